// *** core/usm_map.svh ***
/*
 Register map, field positions and reset values of the synchronous
 master serial port. Assumes inclusion by bare name from core/.
*/
`ifndef USM_MAP_SVH
`define USM_MAP_SVH
// Register indices; byte address is four times the index
`define USM_IX_IFLAG 8'h0C
`define USM_IX_RXCTL 8'h18
`define USM_IX_TXBUF 8'h19
`define USM_IX_RXFIFO 8'h1A
`define USM_IX_IEN 8'h8C
`define USM_IX_TXCTL 8'h98
`define USM_IX_BAUD 8'h99
// Field positions
`define USM_B_RDY 5
`define USM_B_TBE 4
`define USM_B_MASTER 7
`define USM_B_NINE 6
`define USM_B_TRANSMIT_ENABLE 5
`define USM_B_SYNC 4
`define USM_B_SEMPTY 1
`define USM_B_PORT 7
`define USM_B_SINGLE_RECEIVE_ENABLE 5
`define USM_B_CONTINUOUS_RECEIVE_ENABLE 4
`define USM_B_OVR 1
`define USM_B_NTH 0
// Reset values and word lengths
`define USM_RST_TXCTL 8'h02
`define USM_RST_REG 8'h00
`define USM_BITS8 4'h8
`define USM_BITS9 4'h9
`endif

// *** core/usm_pkg.sv ***
/*
 Types for the synchronous master serial port.
 Assumes the compiler reads it before the modules.
*/
package usm_pkg;
  // Link direction
  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_TX = 2'b01,
    MODE_RX = 2'b10
  } usm_mode_t;
  // Two-stage synchroniser
  typedef struct packed {
    logic s1;
    logic s2;
  } usm_sync_t;
  // Baud generator
  typedef struct packed {
    logic [7:0] cnt;
    logic lvl;
  } usm_baud_t;
  // Port core
  typedef struct packed {
    logic ack;
    logic [7:0] rdat;
    logic master, tx9, transmit_enable, sync, transmit_ninth_bit;
    logic port, rx9, single_receive_enable, continuous_receive_enable, ovr;
    logic tie, rie;
    logic [7:0] div;
    logic [7:0] tbuf;
    logic tfull;
    logic [8:0] tsh;
    logic [3:0] tleft;
    logic thold, dout;
    logic [8:0] rsh;
    logic [3:0] rcnt;
    logic [8:0] fq0, fq1;
    logic [1:0] fcnt;
    logic frd;
    usm_mode_t mode;
  } usm_core_t;
endpackage

// *** core/usm_sync2.sv ***
/*
 Two flip-flop synchroniser for one pin level.
 Assumes the pin is asynchronous to clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module usm_sync2 import usm_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Level in and out
  input wire logic d_i,
  output logic q_o
);
  usm_sync_t r, n;

  // Next state
  always_comb begin
    n.s1 = d_i;
    n.s2 = r.s1;
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign q_o = r.s2;
endmodule
`default_nettype wire

// *** core/usm_baud.sv ***
/*
 Baud generator: toggles the shift clock every divisor+1 cycles.
 Assumes run_i and div_i come from registers on clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module usm_baud import usm_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic run_i,
  input wire logic [7:0] div_i,
  // Shift clock and edge enables
  output logic lvl_o,
  output logic rise_o,
  output logic fall_o
);
  usm_baud_t r, n;
  logic tick;

  // Reload count, toggle level at zero
  always_comb begin
    n = r;
    tick = run_i && (r.cnt == 8'h00);
    if (!run_i) begin
      n.cnt = div_i;
      n.lvl = 1'b0;
    end else if (tick) begin
      n.cnt = div_i;
      n.lvl = ~r.lvl;
    end else begin
      n.cnt = r.cnt - 8'h01;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Edge enables lead the level change
  assign lvl_o = r.lvl;
  assign rise_o = tick && !r.lvl;
  assign fall_o = tick && r.lvl;
endmodule
`default_nettype wire

// *** core/usm_core.sv ***
/*
 Synchronous master serial port: Wishbone register file, transmit
 buffer and shifter, receive shifter and two-word FIFO.
 Assumes Wishbone classic master on clk_i; link pins asynchronous.
*/
`timescale 1ns/100ps
`default_nettype none
`include "usm_map.svh"
module usm_core import usm_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Shift clock line
  output logic sclk_o,
  output logic sclk_oe_n_o,
  // Data line
  input wire logic sdata_i,
  output logic sdata_o,
  output logic sdata_oe_n_o,
  // Interrupt request
  output logic irq_o
);
  usm_core_t r, n;
  logic din, lvl, rise, fall, run;
  logic [7:0] idx, rmux, wd;
  logic [8:0] head, rw;
  logic wr, rd, pop, push, full_now, rx_done;
  logic tflag, ready, sempty;
  logic [1:0] cnt1;
  logic [3:0] nbt, nbr;

  // Data line synchroniser
  usm_sync2 u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(sdata_i),
    .q_o(din)
  );

  // Baud generator runs while any enable is set
  assign run = r.transmit_enable || r.continuous_receive_enable || r.single_receive_enable;

  usm_baud u_baud (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run),
    .div_i(r.div),
    .lvl_o(lvl),
    .rise_o(rise),
    .fall_o(fall)
  );

  // Status views of the state
  assign tflag = r.transmit_enable && !r.tfull;
  assign sempty = (r.tleft == 4'h0) && !r.thold;
  assign ready = r.fcnt != 2'b00;
  assign head = r.frd ? r.fq1 : r.fq0;
  assign idx = adr_i[9:2];
  assign wd = dat_i[7:0];
  assign nbt = r.tx9 ? `USM_BITS9 : `USM_BITS8;
  assign nbr = r.rx9 ? `USM_BITS9 : `USM_BITS8;
  assign rx_done = (r.mode == MODE_RX) && fall && ((r.rcnt + 4'h1) == nbr);

  // Read multiplexer, unused bits read zero
  always_comb begin
    case (idx)
      `USM_IX_IFLAG: rmux = {2'b00, ready, tflag, 4'h0};
      `USM_IX_RXCTL: rmux = {r.port, r.rx9, r.single_receive_enable, r.continuous_receive_enable, 2'b00, r.ovr, head[8]};
      `USM_IX_TXBUF: rmux = r.tbuf;
      `USM_IX_RXFIFO: rmux = head[7:0];
      `USM_IX_IEN: rmux = {2'b00, r.rie, r.tie, 4'h0};
      `USM_IX_TXCTL: rmux = {r.master, r.tx9, r.transmit_enable, r.sync, 2'b00, sempty, r.transmit_ninth_bit};
      `USM_IX_BAUD: rmux = r.div;
      default: rmux = 8'h00;
    endcase
  end

  // Next state of the whole port
  always_comb begin
    n = r;
    rw = r.rsh;
    push = 1'b0;
    // Bus: one wait state, ack for one cycle; a write lands at the edge that samples ack
    n.ack = cyc_i && stb_i && !r.ack;
    wr = r.ack && cyc_i && stb_i && we_i && sel_i[0];
    rd = n.ack && !we_i;
    pop = rd && (idx == `USM_IX_RXFIFO) && ready;
    n.rdat = rd ? rmux : 8'h00;
    cnt1 = r.fcnt - {1'b0, pop};
    full_now = cnt1 == 2'b10;

    // Link direction; reception wins over sending
    if (r.continuous_receive_enable || r.single_receive_enable) begin
      n.mode = MODE_RX;
    end else if (r.transmit_enable) begin
      n.mode = MODE_TX;
    end else begin
      n.mode = MODE_IDLE;
    end

    // Transmitter
    case (r.mode)
      MODE_TX: begin
        if (r.tfull && sempty) begin
          n.tsh = {r.transmit_ninth_bit, r.tbuf};
          n.tleft = nbt;
          n.tfull = 1'b0;
        end else if (rise) begin
          if (r.tleft == 4'h0 && r.tfull) begin
            n.dout = r.tbuf[0];
            n.tsh = {1'b0, r.transmit_ninth_bit, r.tbuf[7:1]};
            n.tleft = nbt - 4'h1;
            n.tfull = 1'b0;
            n.thold = 1'b1;
          end else if (r.tleft != 4'h0) begin
            n.dout = r.tsh[0];
            n.tsh = {1'b0, r.tsh[8:1]};
            n.tleft = r.tleft - 4'h1;
            n.thold = 1'b1;
          end else begin
            n.thold = 1'b0;
          end
        end
      end
      MODE_RX: begin
        // Shifter frozen while receiving
      end
      MODE_IDLE: begin
      end
      default: begin
      end
    endcase
    if (!r.transmit_enable) begin
      n.tleft = 4'h0;
      n.thold = 1'b0;
      n.tsh = 9'h000;
    end

    // Register writes; buffer write wins over a same-cycle load
    if (wr) begin
      case (idx)
        `USM_IX_RXCTL: begin
          n.port = wd[`USM_B_PORT];
          n.rx9 = wd[6];
          n.single_receive_enable = wd[`USM_B_SINGLE_RECEIVE_ENABLE];
          n.continuous_receive_enable = wd[`USM_B_CONTINUOUS_RECEIVE_ENABLE];
          if (!wd[`USM_B_CONTINUOUS_RECEIVE_ENABLE]) begin
            n.ovr = 1'b0;
          end
        end
        `USM_IX_TXBUF: begin
          n.tbuf = wd;
          n.tfull = 1'b1;
        end
        `USM_IX_IEN: begin
          n.rie = wd[`USM_B_RDY];
          n.tie = wd[`USM_B_TBE];
        end
        `USM_IX_TXCTL: begin
          n.master = wd[`USM_B_MASTER];
          n.tx9 = wd[`USM_B_NINE];
          n.transmit_enable = wd[`USM_B_TRANSMIT_ENABLE];
          n.sync = wd[`USM_B_SYNC];
          n.transmit_ninth_bit = wd[`USM_B_NTH];
        end
        `USM_IX_BAUD: n.div = wd;
        default: begin
        end
      endcase
    end

    // Receiver samples on the falling shift clock edge
    if (r.mode != MODE_RX) begin
      n.rcnt = 4'h0;
    end else if (fall) begin
      rw[r.rcnt] = din;
      n.rsh = rw;
      n.rcnt = r.rcnt + 4'h1;
      if (rx_done) begin
        n.rcnt = 4'h0;
        n.rsh = 9'h000;
        // Overrun set outranks a same-cycle software clear
        if (full_now) begin
          n.ovr = 1'b1;
        end else if (!r.ovr) begin
          push = 1'b1;
        end
        if (!r.continuous_receive_enable) begin
          n.single_receive_enable = 1'b0;
        end
      end
    end

    // FIFO bookkeeping, pop and push may share a cycle
    n.frd = r.frd ^ pop;
    if (push) begin
      if (n.frd ^ cnt1[0]) begin
        n.fq1 = {r.rx9 && rw[8], rw[7:0]};
      end else begin
        n.fq0 = {r.rx9 && rw[8], rw[7:0]};
      end
    end
    n.fcnt = cnt1 + {1'b0, push};
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Bus outputs
  assign ack_o = r.ack;
  assign dat_o = {24'h000000, r.rdat};

  // Pin drivers, enables active low
  assign sclk_o = lvl;
  assign sclk_oe_n_o = !(r.port && r.sync && r.master && run);
  assign sdata_o = r.dout;
  assign sdata_oe_n_o = !(r.port && r.sync && r.mode == MODE_TX);

  // Interrupt request
  assign irq_o = (tflag && r.tie) || (ready && r.rie);

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_word_done;
    rx_done;
  endsequence

  sequence s_room;
    s_word_done ##0 (!r.ovr && !full_now);
  endsequence

  a_half_duplex: assert property (
    (r.mode == MODE_RX) |-> sdata_oe_n_o)
    else $error("data line driven while receiving");

  a_load_empties: assert property (
    $fell(sempty) |-> $past(r.tfull) && (!r.tfull || $past(wr)))
    else $error("shifter loaded without buffer data");

  a_sempty_read: assert property (
    (rd && idx == `USM_IX_TXCTL) |=> dat_o[1] == $past(sempty))
    else $error("shifter empty bit misread");

  a_baud_hold: assert property (
    !run |-> (!rise && !fall) ##1 !lvl)
    else $error("baud generator ran while held");

  a_abort_float: assert property (
    (!r.transmit_enable && !r.continuous_receive_enable && !r.single_receive_enable) |-> sclk_oe_n_o ##1 sdata_oe_n_o)
    else $error("link lines still driven after abort");

  a_single_word: assert property (
    (s_word_done ##0 !r.continuous_receive_enable) |=> !r.single_receive_enable)
    else $error("single receive enable not cleared");

  a_word_stored: assert property (
    s_room |=> ready ##0 (r.fcnt == $past(cnt1) + 2'b01))
    else $error("received word not stored");

  a_overrun_set: assert property (
    (s_word_done ##0 full_now) |=> r.ovr && r.fcnt == 2'b10)
    else $error("overrun not flagged");

  a_overrun_block: assert property (
    r.ovr |=> r.fcnt <= $past(r.fcnt))
    else $error("FIFO loaded during overrun");

  a_irq_gate: assert property (
    (!r.tie && !r.rie) |-> !irq_o)
    else $error("interrupt not gated");

  // Transmit side
  sequence s_tx_load;
    r.mode == MODE_TX && r.transmit_enable && r.tfull && sempty;
  endsequence

  sequence s_tx_rise;
    r.mode == MODE_TX && r.transmit_enable && rise;
  endsequence

  a_port_float: assert property (
    !r.port |-> sclk_oe_n_o && sdata_oe_n_o)
    else $error("link lines driven with port disabled");

  a_buffer_load: assert property (
    s_tx_load |=> r.tleft == $past(nbt))
    else $error("shifter not loaded from buffer");

  a_flag_clear: assert property (
    (wr && idx == `USM_IX_TXBUF) |=> !tflag)
    else $error("buffer empty flag not cleared by write");

  a_bit_out: assert property (
    (s_tx_rise ##0 r.tleft != 4'h0) |=> sdata_o == $past(r.tsh[0]))
    else $error("transmit bit not shifted on rise");

  a_back_to_back: assert property (
    (s_tx_rise ##0 (r.tleft == 4'h0 && r.tfull && r.thold)) |=> sdata_o == $past(r.tbuf[0]))
    else $error("queued word not started on rise");

  a_tx_reset: assert property (
    !r.transmit_enable |=> sempty)
    else $error("transmitter not reset by disable");

  a_tx_frozen: assert property (
    (r.mode == MODE_RX && r.transmit_enable) |=> r.tsh == $past(r.tsh) && r.tleft == $past(r.tleft))
    else $error("transmitter moved while receiving");

  a_tx_resume: assert property (
    (s_word_done ##0 !r.continuous_receive_enable) |=> (r.transmit_enable && !r.continuous_receive_enable && !r.single_receive_enable) |=> r.mode == MODE_TX)
    else $error("transmit not resumed after single word");

  // Receive side
  a_rx_count: assert property (
    (r.mode == MODE_RX && fall && !rx_done) |=> r.rcnt == $past(r.rcnt) + 4'h1)
    else $error("receive bit not counted on fall");

  a_ready_clear: assert property (
    (r.fcnt == 2'b01 && pop && !push) |=> !ready)
    else $error("ready flag left set after last read");

  a_overrun_clear: assert property (
    (wr && idx == `USM_IX_RXCTL && !wd[`USM_B_CONTINUOUS_RECEIVE_ENABLE] && !rx_done) |=> !r.ovr)
    else $error("overrun not cleared by continuous disable");
endmodule
`default_nettype wire

// *** test/usm_tb_slave.sv ***
/*
 Link slave model: takes a bit at each shift clock fall, puts its next bit out just after.
 Assumes clk_i is the bench clock and the lines are the resolved wire levels.
*/
`timescale 1ns/100ps
`default_nettype none
module usm_tb_slave (
  // Clock and restart
  input wire logic clk_i,
  input wire logic clr_i,
  // Link wire levels
  input wire logic sclk_i,
  input wire logic line_i,
  output logic line_o,
  // Word length, words sent, word taken
  input wire logic [3:0] nbits_i,
  input wire logic [35:0] words_i,
  output logic [8:0] got_o,
  output logic done_o
);
  logic prev_r;
  logic [3:0] cnt_r;
  logic [1:0] wcnt_r;
  logic [1:0] nw;
  logic [8:0] sh_r;
  logic [8:0] nsh;
  // Next shift value and next word number
  assign nsh = {line_i, sh_r[8:1]};
  assign nw = wcnt_r + 2'h1;
  // Sample on fall, change after it so data is steady before the next fall
  always_ff @(posedge clk_i) begin
    prev_r <= sclk_i;
    done_o <= 1'b0;
    if (clr_i) begin
      cnt_r <= 4'h0;
      wcnt_r <= 2'h0;
      sh_r <= 9'h000;
      line_o <= words_i[0];
    end else if (prev_r && !sclk_i) begin
      sh_r <= nsh;
      if (cnt_r == nbits_i - 4'h1) begin
        got_o <= nsh >> (4'h9 - nbits_i);
        done_o <= 1'b1;
        cnt_r <= 4'h0;
        wcnt_r <= nw;
        line_o <= words_i[nw * 9];
      end else begin
        cnt_r <= cnt_r + 4'h1;
        line_o <= words_i[wcnt_r * 9 + cnt_r + 1];
      end
    end
  end
endmodule
`default_nettype wire

// *** test/testbench.sv ***
/*
 Bench for the serial port core: Wishbone driver, link slave, word monitor.
 Assumes usm_pkg and usm_map.svh are on the compile path.
*/
`timescale 1ns/100ps
`default_nettype none
`include "usm_map.svh"
module testbench import usm_pkg::*;;
  logic clk_i, rst_i, cyc, stb, we, clr, ack, sclk, sclk_oe_n, sdo, sdo_oe_n, irq;
  logic sdata_w, sclk_w, line, done;
  logic [9:0] adr;
  logic [31:0] wdat, dat, rs;
  logic [3:0] nbits;
  logic [35:0] words;
  logic [8:0] got;
  logic [7:0] rd, b, base;
  int n_errors, checked, ndone;
  logic [8:0] q[$];
  logic [7:0] ix [7] = '{`USM_IX_IFLAG, `USM_IX_RXCTL, `USM_IX_TXBUF, `USM_IX_IEN,
    `USM_IX_TXCTL, `USM_IX_BAUD, 8'h3F};
  logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
  // Device under test and wire levels
  usm_core u_usm_core (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat), .ack_o(ack), .sclk_o(sclk),
    .sclk_oe_n_o(sclk_oe_n), .sdata_i(sdata_w), .sdata_o(sdo), .sdata_oe_n_o(sdo_oe_n),
    .irq_o(irq));
  assign sdata_w = sdo_oe_n ? line : sdo;
  assign sclk_w = sclk_oe_n ? 1'b0 : sclk;
  usm_tb_slave u_usm_tb_slave (.clk_i(clk_i), .clr_i(clr), .sclk_i(sclk_w),
    .line_i(sdata_w), .line_o(line), .nbits_i(nbits), .words_i(words), .got_o(got),
    .done_o(done));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic chk(input string nm, input logic [8:0] s, input logic [8:0] x);
    checked++;
    if (s !== x) begin
      n_errors++;
      $display("[FAIL] %s exp %h seen %h", nm, x, s);
    end
  endtask
  task automatic give_verdict;
    if (n_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One classic cycle; data taken at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {a, 2'b00};
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    chk("ack", 9'(ack), 9'h1);
    rd = dat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] x);
    wb(1'b0, a, 8'h00);
    chk("reg", 9'(rd), 9'(x));
  endtask
  task automatic pulse_clr;
    @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
  endtask
  task automatic wait_done(input int k);
    int n, t;
    t = ndone + k;
    n = 0;
    while (ndone < t && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
    chk("words", 9'(ndone >= t), 9'h1);
    repeat (4) @(posedge clk_i);
  endtask
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Word monitor: oldest expected word against the slave's capture
  always @(posedge clk_i) begin
    if (done === 1'b1) begin
      ndone++;
      if (q.size() > 0) chk("tx word", got, q.pop_front());
    end
  end
  // Hang guard
  initial begin
    repeat (40000) @(posedge clk_i);
    n_errors++;
    give_verdict();
  end
  // Main sequence
  initial begin
    {rst_i, cyc, stb, we, clr, adr, wdat, words} = {1'b1, 82'h0};
    nbits = 4'h8;
    rs = 32'h9AAB;
    {n_errors, checked, ndone} = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, 8'h3F, 8'hFF);
    for (int i = 0; i < 7; i++) rdc(ix[i], rv[i]);
    wb(1'b1, `USM_IX_BAUD, 8'h03);
    rdc(`USM_IX_BAUD, 8'h03);
    wb(1'b1, `USM_IX_RXCTL, 8'h80);
    wb(1'b1, `USM_IX_IEN, 8'h30);
    for (int p = 0; p < 2; p++) begin
      base = p ? 8'hD1 : 8'h90;
      nbits <= p ? 4'h9 : 4'h8;
      wb(1'b1, `USM_IX_TXCTL, base);
      for (int k = 0; k < 3; k++) begin
        rs = xs(rs);
        b = rs[7:0];
        if (k > 0) begin
          do wb(1'b0, `USM_IX_IFLAG, 8'h00); while (rd !== 8'h10 && checked < 3000);
          chk("tbe flag", 9'(rd), 9'h10);
          chk("irq tbe", 9'(irq), 9'h1);
          chk("clk oe_n", 9'(sclk_oe_n), 9'h0);
        end
        wb(1'b1, `USM_IX_TXBUF, b);
        q.push_back({p[0], b});
        if (k == 0) begin
          wb(1'b1, `USM_IX_TXCTL, base | 8'h20);
          pulse_clr();
          rdc(`USM_IX_TXCTL, base | 8'h20);
        end
      end
      for (int n = 0; n < 3000 && q.size() > 0; n++) @(posedge clk_i);
      chk("drained", 9'(q.size()), 9'h0);
      wb(1'b1, `USM_IX_TXCTL, base);
    end
    wb(1'b1, `USM_IX_TXCTL, 8'h90);
    wb(1'b1, `USM_IX_TXBUF, 8'hA5);
    wb(1'b1, `USM_IX_TXCTL, 8'hB0);
    repeat (12) @(posedge clk_i);
    wb(1'b1, `USM_IX_RXCTL, 8'h90);
    repeat (3) @(posedge clk_i);
    chk("rx oe_n", 9'({sclk_oe_n, sdo_oe_n}), 9'h1);
    wb(1'b1, `USM_IX_RXCTL, 8'h80);
    wb(1'b1, `USM_IX_TXCTL, 8'h90);
    repeat (3) @(posedge clk_i);
    chk("abort oe_n", 9'({sclk_oe_n, sdo_oe_n}), 9'h3);
    rdc(`USM_IX_TXCTL, 8'h92);
    for (int i = 0; i < 4; i++) begin
      rs = xs(rs);
      words[i * 9 +: 9] = {1'b0, rs[7:0]};
    end
    nbits <= 4'h8;
    wb(1'b1, `USM_IX_RXCTL, 8'h90);
    pulse_clr();
    wait_done(3);
    rdc(`USM_IX_RXCTL, 8'h92);
    rdc(`USM_IX_IFLAG, 8'h20);
    chk("irq rdy", 9'(irq), 9'h1);
    rdc(`USM_IX_RXFIFO, words[7:0]);
    rdc(`USM_IX_RXFIFO, words[16:9]);
    rdc(`USM_IX_IFLAG, 8'h00);
    wait_done(1);
    rdc(`USM_IX_IFLAG, 8'h00);
    wb(1'b1, `USM_IX_RXCTL, 8'h80);
    rdc(`USM_IX_RXCTL, 8'h80);
    wb(1'b1, `USM_IX_RXCTL, 8'hA0);
    pulse_clr();
    wait_done(1);
    rdc(`USM_IX_RXCTL, 8'h80);
    rdc(`USM_IX_RXFIFO, words[7:0]);
    wb(1'b1, `USM_IX_TXCTL, 8'hB0);
    wb(1'b1, `USM_IX_RXCTL, 8'hA0);
    pulse_clr();
    wait_done(1);
    chk("resume oe_n", 9'(sdo_oe_n), 9'h0);
    rdc(`USM_IX_RXCTL, 8'h80);
    give_verdict();
  end
endmodule
`default_nettype wire
